//--- twm_pkg.sv
// Purpose: shared constants, field layout and carrier types of the waveform mode control.
// Assumes: one 16-bit timer per instance; counter and compare units sit outside.
// Notes: register offsets are byte addresses on the AHB-Lite slave.
package twm_pkg;

	localparam int TWM_ADDR_W = 8;
	localparam logic [TWM_ADDR_W-1:0] TWM_OFS_CTRL_A = 8'h00;
	localparam logic [TWM_ADDR_W-1:0] TWM_OFS_CTRL_B = 8'h04;
	localparam logic [TWM_ADDR_W-1:0] TWM_OFS_STATUS = 8'h08;

	// control A: output modes, force strobes, low mode bits
	localparam int TWM_COM_A_POS = 6;
	localparam int TWM_COM_B_POS = 4;
	localparam int TWM_FORCE_A_BIT = 3;
	localparam int TWM_FORCE_B_BIT = 2;
	localparam int TWM_WGM_LO_POS = 0;
	// control B: high mode bits
	localparam int TWM_WGM_HI_POS = 3;
	// status
	localparam int TWM_ST_PIN_A = 0;
	localparam int TWM_ST_PIN_B = 1;
	localparam int TWM_ST_DRIVE_A = 2;
	localparam int TWM_ST_DRIVE_B = 3;
	localparam int TWM_ST_CAP_EN = 4;

	localparam logic [7:0] TWM_CTRL_A_RESET = 8'h00;
	localparam logic [1:0] TWM_WGM_HI_RESET = 2'h0;
	localparam logic [7:0] TWM_CTRL_A_KEEP = 8'hf3;

	localparam logic [1:0] TWM_COM_OFF = 2'h0;
	localparam logic [1:0] TWM_COM_TOGGLE = 2'h1;

	localparam logic [15:0] TWM_TOP_VAL_MAX = 16'hffff;
	localparam logic [15:0] TWM_TOP_VAL_8 = 16'h00ff;
	localparam logic [15:0] TWM_TOP_VAL_9 = 16'h01ff;
	localparam logic [15:0] TWM_TOP_VAL_10 = 16'h03ff;

	localparam logic [1:0] TWM_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] TWM_HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		TWM_KIND_NONPWM = 2'h0,
		TWM_KIND_FAST = 2'h1,
		TWM_KIND_PHASE = 2'h2,
		TWM_KIND_PFC = 2'h3
	} twm_kind_t;

	typedef enum logic [2:0] {
		TWM_TOP_MAX = 3'h0,
		TWM_TOP_8 = 3'h1,
		TWM_TOP_9 = 3'h2,
		TWM_TOP_10 = 3'h3,
		TWM_TOP_CMP_A = 3'h4,
		TWM_TOP_CAPTURE = 3'h5
	} twm_top_t;

	typedef enum logic [1:0] {
		TWM_PT_IMMEDIATE = 2'h0,
		TWM_PT_TOP = 2'h1,
		TWM_PT_BOTTOM = 2'h2,
		TWM_PT_MAX = 2'h3
	} twm_point_t;

	typedef struct packed {
		twm_kind_t kind;
		twm_top_t top;
		twm_point_t update;
		twm_point_t overflow;
	} twm_mode_t;

	// one-cycle qualified events from the counter, plus its direction
	typedef struct packed {
		logic match_a;
		logic match_b;
		logic at_top;
		logic at_bottom;
		logic at_max;
		logic down;
		logic cmp_a_is_top;
		logic cmp_b_is_top;
	} twm_cnt_t;

	typedef struct packed {
		logic pin_a;
		logic pin_b;
		logic drive_a;
		logic drive_b;
	} twm_pins_t;

	typedef struct packed {
		logic buffer_update;
		logic overflow_set;
		logic flag_set_a;
		logic flag_set_b;
		logic ctc_clear;
		logic capture_enable;
		logic capture_in;
	} twm_events_t;

endpackage

//--- twm_mode_decode.sv
// Purpose: decode the four waveform mode bits into count kind, TOP source and event points.
// Assumes: purely combinational; the caller registers what it needs.
// Notes: the reserved code is decoded as normal, so compare pins still act on matches and force strobes.
`timescale 1ns/1ps
module twm_mode_decode
	import twm_pkg::*;
(
	input wire logic [3:0] waveform_mode_select,
	output twm_mode_t mode
);

	always_comb begin
		mode = '{TWM_KIND_NONPWM, TWM_TOP_MAX, TWM_PT_IMMEDIATE, TWM_PT_MAX};
		unique case (waveform_mode_select)
			4'h0: mode = '{TWM_KIND_NONPWM, TWM_TOP_MAX, TWM_PT_IMMEDIATE, TWM_PT_MAX};
			4'h1: mode = '{TWM_KIND_PHASE, TWM_TOP_8, TWM_PT_TOP, TWM_PT_BOTTOM};
			4'h2: mode = '{TWM_KIND_PHASE, TWM_TOP_9, TWM_PT_TOP, TWM_PT_BOTTOM};
			4'h3: mode = '{TWM_KIND_PHASE, TWM_TOP_10, TWM_PT_TOP, TWM_PT_BOTTOM};
			4'h4: mode = '{TWM_KIND_NONPWM, TWM_TOP_CMP_A, TWM_PT_IMMEDIATE, TWM_PT_MAX};
			4'h5: mode = '{TWM_KIND_FAST, TWM_TOP_8, TWM_PT_TOP, TWM_PT_TOP};
			4'h6: mode = '{TWM_KIND_FAST, TWM_TOP_9, TWM_PT_TOP, TWM_PT_TOP};
			4'h7: mode = '{TWM_KIND_FAST, TWM_TOP_10, TWM_PT_TOP, TWM_PT_TOP};
			4'h8: mode = '{TWM_KIND_PFC, TWM_TOP_CAPTURE, TWM_PT_BOTTOM, TWM_PT_BOTTOM};
			4'h9: mode = '{TWM_KIND_PFC, TWM_TOP_CMP_A, TWM_PT_BOTTOM, TWM_PT_BOTTOM};
			4'ha: mode = '{TWM_KIND_PHASE, TWM_TOP_CAPTURE, TWM_PT_TOP, TWM_PT_BOTTOM};
			4'hb: mode = '{TWM_KIND_PHASE, TWM_TOP_CMP_A, TWM_PT_TOP, TWM_PT_BOTTOM};
			4'hc: mode = '{TWM_KIND_NONPWM, TWM_TOP_CAPTURE, TWM_PT_IMMEDIATE, TWM_PT_MAX};
			// reserved code: no sequence defined, behave as normal
			4'hd: mode = '{TWM_KIND_NONPWM, TWM_TOP_MAX, TWM_PT_IMMEDIATE, TWM_PT_MAX};
			4'he: mode = '{TWM_KIND_FAST, TWM_TOP_CAPTURE, TWM_PT_TOP, TWM_PT_TOP};
			4'hf: mode = '{TWM_KIND_FAST, TWM_TOP_CMP_A, TWM_PT_TOP, TWM_PT_TOP};
		endcase
	end

endmodule

//--- twm_waveform_ctrl.sv
// Purpose: control register A of a 16-bit timer and the waveform mode logic it steers.
// Assumes: counter events arrive on hclk, already qualified by the timer tick.
// Notes: zero-wait AHB-Lite slave; tmr_en freezes the waveform state only.
`timescale 1ns/1ps
module twm_waveform_ctrl
	import twm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tmr_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input twm_cnt_t cnt,
	input wire logic capture_pin,
	output twm_pins_t pins,
	output twm_events_t events,
	output twm_top_t top_sel,
	output logic [15:0] top_value
);

	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [1:0] wgm_hi;
		logic force_a;
		logic force_b;
		logic wr_pend;
		logic [TWM_ADDR_W-1:0] wr_addr;
		logic ready;
		logic resp;
		logic [31:0] rdata;
		twm_pins_t pins;
		twm_events_t ev;
		twm_top_t top_sel;
		logic [15:0] top_value;
		logic cap_sync1;
		logic cap_sync2;
	} twm_state_t;

	localparam twm_state_t TWM_STATE_RESET = '{
		ctrl_a: TWM_CTRL_A_RESET,
		wgm_hi: TWM_WGM_HI_RESET,
		force_a: 1'b0,
		force_b: 1'b0,
		wr_pend: 1'b0,
		wr_addr: '0,
		ready: 1'b1,
		resp: 1'b0,
		rdata: '0,
		pins: '0,
		ev: '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
		top_sel: TWM_TOP_MAX,
		top_value: TWM_TOP_VAL_MAX,
		cap_sync1: 1'b0,
		cap_sync2: 1'b0
	};

	twm_state_t st_reg;
	twm_state_t st_next;
	twm_mode_t mode;
	logic [3:0] mode_bits;

	// next level of one compare pin for the current mode and counter events
	function automatic logic twm_pin_step(
		input twm_kind_t kind,
		input logic [1:0] com,
		input logic wgm3,
		input logic is_b,
		input logic hit,
		input logic at_top,
		input logic down,
		input logic cmp_is_top,
		input logic cur
	);
		logic r;
		logic toggle_ok;
		r = cur;
		toggle_ok = (com == TWM_COM_TOGGLE) && wgm3 && !is_b;
		unique case (kind)
			TWM_KIND_NONPWM: begin
				if (hit) begin
					if (com == TWM_COM_TOGGLE) begin
						r = !cur;
					end else if (com[1]) begin
						r = com[0];
					end
				end
			end
			TWM_KIND_FAST: begin
				if (com[1]) begin
					if (at_top) begin
						r = !com[0];
					end
					// a match on TOP itself would fight the TOP action
					if (hit && !cmp_is_top) begin
						r = com[0];
					end
				end else if (toggle_ok && hit) begin
					r = !cur;
				end
			end
			TWM_KIND_PHASE, TWM_KIND_PFC: begin
				if (com[1]) begin
					if (hit) begin
						r = down ? !com[0] : com[0];
					end
				end else if (toggle_ok && hit) begin
					r = !cur;
				end
			end
		endcase
		return r;
	endfunction

	// whether the compare unit takes the pin away from the port
	function automatic logic twm_drive(
		input twm_kind_t kind,
		input logic [1:0] com,
		input logic wgm3,
		input logic is_b
	);
		logic quiet_toggle;
		// toggle is undefined for B in PWM, so B stays on the port there
		quiet_toggle = (kind != TWM_KIND_NONPWM) && (com == TWM_COM_TOGGLE) && (!wgm3 || is_b);
		return (com != TWM_COM_OFF) && !quiet_toggle;
	endfunction

	function automatic logic twm_event_at(input twm_point_t pt, input twm_cnt_t c);
		logic r;
		r = 1'b0;
		unique case (pt)
			TWM_PT_IMMEDIATE: r = 1'b1;
			TWM_PT_TOP: r = c.at_top;
			TWM_PT_BOTTOM: r = c.at_bottom;
			TWM_PT_MAX: r = c.at_max;
		endcase
		return r;
	endfunction

	assign mode_bits = {st_reg.wgm_hi, st_reg.ctrl_a[TWM_WGM_LO_POS +: 2]};

	twm_mode_decode u_decode (
		.waveform_mode_select(mode_bits),
		.mode(mode)
	);

	always_comb begin
		logic hit_a;
		logic hit_b;
		logic wgm3;
		logic take;
		logic pwm_after;
		logic [3:0] bits_after;
		logic [7:0] status;
		logic [31:0] rd;
		hit_a = 1'b0;
		hit_b = 1'b0;
		wgm3 = st_reg.wgm_hi[1];
		take = 1'b0;
		pwm_after = 1'b0;
		bits_after = '0;
		status = '0;
		rd = '0;
		st_next = st_reg;

		// waveform side, frozen while the timer clock enable is low
		if (tmr_en) begin
			hit_a = cnt.match_a || (st_reg.force_a && mode.kind == TWM_KIND_NONPWM);
			hit_b = cnt.match_b || (st_reg.force_b && mode.kind == TWM_KIND_NONPWM);
			st_next.force_a = 1'b0;
			st_next.force_b = 1'b0;
			st_next.pins.pin_a = twm_pin_step(mode.kind, st_reg.ctrl_a[TWM_COM_A_POS +: 2], wgm3,
				1'b0, hit_a, cnt.at_top, cnt.down, cnt.cmp_a_is_top, st_reg.pins.pin_a);
			st_next.pins.pin_b = twm_pin_step(mode.kind, st_reg.ctrl_a[TWM_COM_B_POS +: 2], wgm3,
				1'b1, hit_b, cnt.at_top, cnt.down, cnt.cmp_b_is_top, st_reg.pins.pin_b);
			st_next.pins.drive_a = twm_drive(mode.kind, st_reg.ctrl_a[TWM_COM_A_POS +: 2], wgm3,
				1'b0);
			st_next.pins.drive_b = twm_drive(mode.kind, st_reg.ctrl_a[TWM_COM_B_POS +: 2], wgm3,
				1'b1);
			// flags follow real matches only; counter clear follows match A or TOP, never a force strobe
			st_next.ev.flag_set_a = cnt.match_a;
			st_next.ev.flag_set_b = cnt.match_b;
			st_next.ev.ctc_clear = (mode.kind == TWM_KIND_NONPWM) && (
				(mode.top == TWM_TOP_CMP_A && cnt.match_a) ||
				(mode.top == TWM_TOP_CAPTURE && cnt.at_top));
			st_next.ev.buffer_update = twm_event_at(mode.update, cnt);
			st_next.ev.overflow_set = twm_event_at(mode.overflow, cnt);
			st_next.ev.capture_enable = (mode.top != TWM_TOP_CAPTURE);
			st_next.ev.capture_in = st_reg.cap_sync2 && (mode.top != TWM_TOP_CAPTURE);
			st_next.cap_sync1 = capture_pin;
			st_next.cap_sync2 = st_reg.cap_sync1;
			st_next.top_sel = mode.top;
			unique case (mode.top)
				TWM_TOP_MAX: st_next.top_value = TWM_TOP_VAL_MAX;
				TWM_TOP_8: st_next.top_value = TWM_TOP_VAL_8;
				TWM_TOP_9: st_next.top_value = TWM_TOP_VAL_9;
				TWM_TOP_10: st_next.top_value = TWM_TOP_VAL_10;
				// register-defined tops: the counter picks the value
				TWM_TOP_CMP_A, TWM_TOP_CAPTURE: st_next.top_value = '0;
			endcase
		end

		// bus data phase: the write lands after the timer section so a new strobe wins
		if (st_reg.wr_pend) begin
			st_next.wr_pend = 1'b0;
			unique case (st_reg.wr_addr)
				TWM_OFS_CTRL_A: begin
					st_next.ctrl_a = hwdata[7:0] & TWM_CTRL_A_KEEP;
					bits_after = {st_reg.wgm_hi, hwdata[TWM_WGM_LO_POS +: 2]};
					pwm_after = !(bits_after == 4'h0 || bits_after == 4'h4 ||
						bits_after == 4'hc || bits_after == 4'hd);
					if (!pwm_after) begin
						st_next.force_a = st_next.force_a || hwdata[TWM_FORCE_A_BIT];
						st_next.force_b = st_next.force_b || hwdata[TWM_FORCE_B_BIT];
					end
				end
				TWM_OFS_CTRL_B: st_next.wgm_hi = hwdata[TWM_WGM_HI_POS +: 2];
				default: ;
			endcase
		end

		// bus address phase
		take = hsel && hready && (htrans == TWM_HTRANS_NONSEQ);
		st_next.ready = 1'b1;
		st_next.resp = 1'b0;
		st_next.rdata = '0;
		if (take) begin
			if (hwrite) begin
				// only whole-word writes are honoured
				st_next.wr_pend = (hsize == TWM_HSIZE_WORD);
				st_next.wr_addr = haddr[TWM_ADDR_W-1:0];
			end else begin
				status[TWM_ST_PIN_A] = st_reg.pins.pin_a;
				status[TWM_ST_PIN_B] = st_reg.pins.pin_b;
				status[TWM_ST_DRIVE_A] = st_reg.pins.drive_a;
				status[TWM_ST_DRIVE_B] = st_reg.pins.drive_b;
				status[TWM_ST_CAP_EN] = st_reg.ev.capture_enable;
				// read the post-write copy so a read right after a write sees it
				unique case (haddr[TWM_ADDR_W-1:0])
					TWM_OFS_CTRL_A: rd[7:0] = st_next.ctrl_a;
					TWM_OFS_CTRL_B: rd[TWM_WGM_HI_POS +: 2] = st_next.wgm_hi;
					TWM_OFS_STATUS: rd[7:0] = status;
					default: rd = '0;
				endcase
				st_next.rdata = rd;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= TWM_STATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hreadyout = st_reg.ready;
	assign hresp = st_reg.resp;
	assign hrdata = st_reg.rdata;
	assign pins = st_reg.pins;
	assign events = st_reg.ev;
	assign top_sel = st_reg.top_sel;
	assign top_value = st_reg.top_value;

endmodule

//--- twm_props.sv
// Purpose: port-level checks of the waveform mode control
// Assumes: only word transfers reach the registers
// Notes: control A/B are shadowed from bus traffic, so no internal probes are needed
`timescale 1ns/1ps
module twm_props
	import twm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tmr_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input twm_cnt_t cnt,
	input wire logic capture_pin,
	input twm_pins_t pins,
	input twm_events_t events,
	input twm_top_t top_sel,
	input wire logic [15:0] top_value
);
	logic [7:0] ca, adr;
	logic [1:0] ch, ka;
	logic [3:0] md;
	logic [15:0] tv;
	logic tk, wp, rp, nonp, fst, ovf, capm;
	assign md = {ch, ca[1:0]};
	assign ka = ca[7:6];
	assign tk = hsel && hready && htrans == TWM_HTRANS_NONSEQ && hsize == TWM_HSIZE_WORD;
	assign nonp = md inside {4'd0, 4'd4, 4'd12, 4'd13};
	assign fst = md inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15};
	assign capm = md inside {4'd8, 4'd10, 4'd12, 4'd14};
	assign ovf = nonp ? cnt.at_max : (fst ? cnt.at_top : cnt.at_bottom);
	// register-defined tops report zero, the reserved code behaves as normal
	assign tv = (md == 4'd0 || md == 4'd13) ? TWM_TOP_VAL_MAX :
		(md[3] || md[1:0] == 2'h0) ? 16'h0000 :
		(md[1:0] == 2'h1 ? TWM_TOP_VAL_8 : (md[1:0] == 2'h2 ? TWM_TOP_VAL_9 : TWM_TOP_VAL_10));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ca <= 8'h00;
			ch <= 2'h0;
			wp <= 1'b0;
			rp <= 1'b0;
			adr <= 8'h00;
		end else begin
			if (wp && adr == TWM_OFS_CTRL_A)
				ca <= hwdata[7:0];
			if (wp && adr == TWM_OFS_CTRL_B)
				ch <= hwdata[4:3];
			wp <= tk && hwrite;
			rp <= tk && !hwrite && haddr[7:0] == TWM_OFS_CTRL_A;
			adr <= haddr[7:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_fast_top;
		tmr_en && fst && ka[1] && cnt.at_top && !cnt.match_a;
	endsequence
	sequence s_dual_hit;
		tmr_en && !nonp && !fst && ka == 2'b10 && cnt.match_a && !cnt.cmp_a_is_top;
	endsequence
	a_ctrl_readback: assert property (rp |-> hrdata == {24'h0, ca & TWM_CTRL_A_KEEP})
		else $error("control A readback wrong");
	a_top_fixed: assert property (tmr_en |=> top_value == $past(tv))
		else $error("top value wrong for mode");
	a_ovf_point: assert property (tmr_en |=> events.overflow_set == $past(ovf))
		else $error("overflow at wrong point");
	a_capture_gate: assert property (tmr_en |=> events.capture_enable == !$past(capm))
		else $error("capture enable wrong");
	a_flag_real: assert property (tmr_en && !cnt.cmp_a_is_top
		|=> events.flag_set_a == $past(cnt.match_a))
		else $error("flag a not tied to real match");
	a_drive_route: assert property (tmr_en && nonp |=> pins.drive_a == |$past(ka))
		else $error("pin a routing wrong");
	a_chb_reserved: assert property (tmr_en && !nonp && ca[5:4] == 2'b01 |=> !pins.drive_b)
		else $error("pin b driven in reserved setting");
	a_nonpwm_toggle: assert property (tmr_en && nonp && ka == 2'b01 && cnt.match_a
		|=> pins.pin_a != $past(pins.pin_a))
		else $error("pin a did not toggle");
	a_dual_slope: assert property (s_dual_hit |=> pins.pin_a == $past(cnt.down))
		else $error("dual slope pin a wrong");
	a_fast_top: assert property (s_fast_top |=> pins.pin_a == ($past(ka) == 2'b10))
		else $error("fast top action wrong");
endmodule
bind twm_waveform_ctrl twm_props i_props (.hclk(hclk), .hresetn(hresetn), .tmr_en(tmr_en),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .cnt(cnt), .capture_pin(capture_pin), .pins(pins),
	.events(events), .top_sel(top_sel), .top_value(top_value));

//--- tb.sv
// Purpose: self-checking bench of the waveform mode control
// Assumes: zero-wait slave, but the master still polls ready
// Notes: random counter events; pin model only compares once its level is known
`timescale 1ns/1ps
module tb
	import twm_pkg::*;
();
	logic hclk, hresetn, tmr_en, hsel, hwrite, hreadyout, hresp, cap, rdy, p, k, da;
	logic [31:0] haddr, hwdata, hrdata, rdat, q, lf;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] top_value;
	logic [7:0] fa [3] = '{8'hc8, 8'h88, 8'h48};
	twm_cnt_t cnt, v;
	twm_pins_t pins;
	twm_events_t ev;
	int failures, tests_run, kd;
	twm_waveform_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .tmr_en(tmr_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cnt(cnt),
		.capture_pin(cap), .pins(pins), .events(ev), .top_sel(), .top_value(top_value));
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// sampled mid-cycle so the edge that ends a data phase never races the read
	always @(negedge hclk) begin
		rdat <= hrdata;
		rdy <= hreadyout;
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// entered just after a rising edge; returns at the edge ending the data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= TWM_HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= TWM_HSIZE_WORD;
		do @(posedge hclk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		do @(posedge hclk); while (rdy !== 1'b1);
		q = rdat;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		report_and_stop();
	end
	initial begin
		hresetn = 1'b0;
		tmr_en = 1'b1;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = '0;
		cnt = '0;
		cap = 1'b0;
		p = 1'b0;
		failures = 0;
		tests_run = 0;
		lf = 32'd67342;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, TWM_OFS_STATUS, 32'h0);
		chk(q, 32'h10);
		ahb(1'b0, TWM_OFS_CTRL_A, 32'h0);
		chk(q, 32'h0);
		ahb(1'b1, 8'h0c, 32'hff);
		ahb(1'b0, 8'h0c, 32'h0);
		chk(q, 32'h0);
		ahb(1'b1, TWM_OFS_CTRL_B, 32'hff);
		ahb(1'b0, TWM_OFS_CTRL_B, 32'h0);
		chk(q, 32'h18);
		ahb(1'b1, TWM_OFS_CTRL_B, 32'h0);
		foreach (fa[i]) begin
			ahb(1'b1, TWM_OFS_CTRL_A, {24'h0, fa[i]});
			ahb(1'b0, TWM_OFS_CTRL_A, 32'h0);
			chk(q, {24'h0, fa[i] & 8'hf3});
			chk(pins.pin_a, fa[i][6]);
		end
		ahb(1'b1, TWM_OFS_CTRL_B, 32'h08);
		ahb(1'b1, TWM_OFS_CTRL_A, 32'h89);
		ahb(1'b0, TWM_OFS_CTRL_A, 32'h0);
		chk(pins.pin_a, 1'b1);
		for (int m = 0; m < 16; m++) begin
			if (m == 13)
				continue;
			for (int c = 0; c < 4; c++) begin
				ahb(1'b1, TWM_OFS_CTRL_B, 32'(m[3:2]) << TWM_WGM_HI_POS);
				ahb(1'b1, TWM_OFS_CTRL_A, 32'({c[1:0], c[1:0], 2'h0, m[1:0]}));
				kd = m inside {0, 4, 12, 13} ? 0 : (m inside {5, 6, 7, 14, 15} ? 1 : 2);
				da = c != 0 && !(kd != 0 && c == 1 && m < 8);
				k = 1'b0;
				repeat (6) begin
					lf = nx(lf);
					v = lf[7:0];
					if (kd != 1)
						v.cmp_a_is_top = 1'b0;
					cnt <= v;
					cap <= lf[9];
					@(posedge hclk);
					cnt <= '0;
					if (!da)
						k = 1'b0;
					else if (kd == 0 || c == 1) begin
						if (v.match_a && c == 1)
							p = !p;
						else if (v.match_a) begin
							p = c == 3;
							k = 1'b1;
						end
					end else if (kd == 1 && v.match_a && !v.cmp_a_is_top) begin
						p = c == 3;
						k = 1'b1;
					end else if (kd == 1 && v.at_top) begin
						p = c == 2;
						k = 1'b1;
					end else if (kd == 2 && v.match_a) begin
						p = c == 2 ? v.down : !v.down;
						k = 1'b1;
					end
					@(negedge hclk);
					// the port direction bit sits outside; drive_a is what it gates
					chk(pins.drive_a, da);
					chk(pins.drive_b, c != 0 && !(kd != 0 && c == 1));
					chk(ev.overflow_set, kd == 0 ? v.at_max : (kd == 1 ? v.at_top : v.at_bottom));
					chk(ev.buffer_update, kd == 0 ? 1'b1 : (m inside {8, 9} ? v.at_bottom : v.at_top));
					chk(ev.ctc_clear, m == 4 ? v.match_a : (m == 12 ? v.at_top : 1'b0));
					chk(ev.capture_enable, !(m inside {8, 10, 12, 14}));
					if (m inside {8, 10, 12, 14})
						chk(ev.capture_in, 1'b0);
					chk(top_value, (m == 0 || m == 13) ? TWM_TOP_VAL_MAX : (m > 7 || m % 4 == 0) ? 16'h0 :
						(m % 4 == 1 ? TWM_TOP_VAL_8 : (m % 4 == 2 ? TWM_TOP_VAL_9 : TWM_TOP_VAL_10)));
					if (!v.cmp_a_is_top)
						chk(ev.flag_set_a, v.match_a);
					if (k)
						chk(pins.pin_a, p);
					@(posedge hclk);
				end
			end
		end
		// clock enable low must freeze the pin and the flag pulse
		ahb(1'b1, TWM_OFS_CTRL_B, 32'h0);
		ahb(1'b1, TWM_OFS_CTRL_A, 32'hc8);
		ahb(1'b1, TWM_OFS_CTRL_A, 32'h40);
		v = '0;
		v.match_a = 1'b1;
		tmr_en <= 1'b0;
		cnt <= v;
		@(posedge hclk);
		cnt <= '0;
		@(negedge hclk);
		chk(pins.pin_a, 1'b1);
		chk(ev.flag_set_a, 1'b0);
		@(posedge hclk);
		tmr_en <= 1'b1;
		cnt <= v;
		@(posedge hclk);
		cnt <= '0;
		@(negedge hclk);
		chk(pins.pin_a, 1'b0);
		chk(ev.flag_set_a, 1'b1);
		report_and_stop();
	end
endmodule
